/* File: core/adct_consts.svh */
// Named constants for the dual converter output timing core.
`ifndef ADCT_CONSTS_SVH
`define ADCT_CONSTS_SVH
`define ADCT_DW              14
`define ADCT_LAT_CYC         12
`define ADCT_CLK_MHZ         40
`define ADCT_CLK_KSPS        40000
`define ADCT_WAKE_US         500
`define ADCT_MIN_KSPS_DCS    20000
`define ADCT_MIN_KSPS_NODCS  10000
`define ADCT_AW              12
`define ADCT_IDX_CFG         8'h08
`define ADCT_IDX_STAT        8'h09
`define ADCT_IDX_DLY         8'h17
`define ADCT_CFG_RST         8'h04
`define ADCT_DLY_RST         5'h00
`define ADCT_DLY_W           5
`define ADCT_DLY_TAPS        32
`define ADCT_SPI_INSTR_LAST  5'h0F
`define ADCT_SPI_FRAME_LAST  5'h17
`define ADCT_FIFO_DEPTH      4
`define ADCT_RESP_OK         2'h0
`define ADCT_RESP_SLVERR     2'h2
`endif

/* File: core/adct_pkg.sv */
// Types shared by the dual converter output timing core.
`include "adct_consts.svh"
package adct_pkg;
   typedef struct packed {
      logic [`ADCT_DW-1:0] a;
      logic [`ADCT_DW-1:0] b;
   } adct_pair_t;
   typedef struct packed {
      logic       vld;
      adct_pair_t d;
   } adct_samp_t;
   typedef struct packed {
      logic       sync_en;
      logic [2:0] div_m1;
      logic       rsvd;
      logic       dcs_en;
      logic       lvds;
      logic       pdwn;
   } adct_cfg_t;
   typedef enum logic [2:0] {
      PW_DOWN = 3'h1,
      PW_WAKE = 3'h2,
      PW_RUN  = 3'h4
   } adct_pwr_t;
   typedef enum logic [4:0] {
      SP_IDLE  = 5'h01,
      SP_INSTR = 5'h02,
      SP_WDATA = 5'h04,
      SP_RDATA = 5'h08,
      SP_DONE  = 5'h10
   } adct_spi_t;
endpackage

/* File: core/adct_sync3.sv */
// Three-stage pin synchroniser whose output follows once stages two and three agree.
`timescale 1ns/100ps
module adct_sync3 #(
   parameter int unsigned W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   wire  [W-1:0] agree = s2_q ~^ s3_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         o_q  <= RST;
      end else begin
         s1_q <= i_d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         o_q  <= (agree & s3_q) | (~agree & o_q);
      end
   end
endmodule

/* File: core/adct_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module adct_fifo #(
   parameter int unsigned W     = 8,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic      [W-1:0] o_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   wire push = i_valid && o_ready;
   wire pop  = o_valid && i_ready;

   assign o_ready = cnt_q != DEPTH[AW:0];
   assign o_valid = cnt_q != '0;
   assign o_data  = mem_q[rp_q];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wp_q] <= i_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= push ? AW'(wp_q + 1'b1) : wp_q;
         rp_q  <= pop ? AW'(rp_q + 1'b1) : rp_q;
         cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      end
   end
endmodule

/* File: core/adct_top.sv */
// Output timing, power state, serial port and register file of a dual sampling converter.
// Functional notes
// - Single-ended mode: data out 12 samples later.
// - Differential: A at 12, B floor(div/2) cycles later (half a sample at even dividers).
// - Output invalid for 500 us after power-down.
// - Five-bit data clock delay in register 0x17.
// - Rate is clock over divider; floor flagged.
// - Serial pin turns to output on falling clock.
// - Serial pin released on rising clock after read.
// - Sync changes away from edge; sampled rising.
`timescale 1ns/100ps
`include "adct_consts.svh"
module adct_top
   import adct_pkg::*;
#(
   parameter int unsigned P_WAKE_CYC = `ADCT_WAKE_US * `ADCT_CLK_MHZ
) (
   input  wire logic                i_clk,
   input  wire logic                i_rst_n,
   input  wire logic [`ADCT_AW-1:0] i_s_axi_awaddr,
   input  wire logic                i_s_axi_awvalid,
   output logic                     o_s_axi_awready,
   input  wire logic [31:0]         i_s_axi_wdata,
   input  wire logic [3:0]          i_s_axi_wstrb,
   input  wire logic                i_s_axi_wvalid,
   output logic                     o_s_axi_wready,
   output logic [1:0]               o_s_axi_bresp,
   output logic                     o_s_axi_bvalid,
   input  wire logic                i_s_axi_bready,
   input  wire logic [`ADCT_AW-1:0] i_s_axi_araddr,
   input  wire logic                i_s_axi_arvalid,
   output logic                     o_s_axi_arready,
   output logic [31:0]              o_s_axi_rdata,
   output logic [1:0]               o_s_axi_rresp,
   output logic                     o_s_axi_rvalid,
   input  wire logic                i_s_axi_rready,
   input  wire logic                i_conv_valid,
   input  wire adct_pair_t          i_conv_data,
   output logic                     o_conv_ready,
   input  wire logic                i_sync,
   input  wire logic                i_sclk,
   input  wire logic                i_serial_select_low_n,
   input  wire logic                i_sdio,
   output logic                     o_sdio,
   output logic                     o_sdio_oe,
   output logic [`ADCT_DW-1:0]      o_data_a,
   output logic [`ADCT_DW-1:0]      o_data_b,
   output logic                     o_data_chan_b,
   output logic                     o_data_valid,
   output logic                     o_output_data_clock,
   output logic                     o_awake
);
   function automatic logic [7:0] reg_index(input logic [`ADCT_AW-1:0] addr);
      return addr[9:2];
   endfunction

   function automatic logic idx_mapped(input logic [7:0] idx);
      return idx == `ADCT_IDX_CFG || idx == `ADCT_IDX_STAT || idx == `ADCT_IDX_DLY;
   endfunction

   function automatic logic [7:0] reg_read(input logic [7:0] idx, input adct_cfg_t cfg,
                                           input logic [`ADCT_DLY_W-1:0] dly,
                                           input logic [7:0] stat);
      logic [7:0] v;
      v = 8'h00;
      if (idx == `ADCT_IDX_CFG) begin
         v = cfg;
      end else if (idx == `ADCT_IDX_STAT) begin
         v = stat;
      end else if (idx == `ADCT_IDX_DLY) begin
         v = {3'h0, dly};
      end
      return v;
   endfunction

   adct_cfg_t               cfg_q;
   logic [`ADCT_DLY_W-1:0]  dly_q;
   adct_pwr_t               pwr_q;
   logic [31:0]             wake_cnt_q;
   logic [2:0]              cnt_q;
   logic                    sync_q;
   logic                    sync_prev_q;
   adct_samp_t              samp_q;
   adct_samp_t              pipe_q [`ADCT_LAT_CYC-1];
   logic [`ADCT_DW-1:0]     b_hold_q;
   logic [`ADCT_DLY_TAPS-1:0] rise_sh_q;
   logic [`ADCT_DLY_TAPS-1:0] fall_sh_q;
   adct_pair_t              fifo_data;
   logic                    fifo_vld;

   // Bus slave: address and data are latched separately, so either may come first.
   logic       aw_got_q;
   logic       w_got_q;
   logic [7:0] aw_idx_q;
   logic [7:0] w_byte_q;
   logic       w_en_q;
   wire        aw_hs  = i_s_axi_awvalid && o_s_axi_awready;
   wire        w_hs   = i_s_axi_wvalid && o_s_axi_wready;
   wire        axi_wr = aw_got_q && w_got_q && !o_s_axi_bvalid;
   wire        ar_hs  = i_s_axi_arvalid && o_s_axi_arready;
   wire [7:0]  ar_idx = reg_index(i_s_axi_araddr);
   assign o_s_axi_awready = !aw_got_q && !o_s_axi_bvalid;
   assign o_s_axi_wready  = !w_got_q && !o_s_axi_bvalid;
   assign o_s_axi_arready = !o_s_axi_rvalid;

   // Serial port signals.
   logic [2:0]  pin_f;
   logic        sclk_prev_q;
   adct_spi_t   sp_q;
   logic [4:0]  bit_q;
   logic [15:0] sh_q;
   logic [7:0]  rd_q;
   wire         sclk_f  = pin_f[2];
   wire         sel     = !pin_f[1];
   wire         sdio_f  = pin_f[0];
   wire         sclk_rise = sclk_f && !sclk_prev_q;
   wire         sclk_fall = !sclk_f && sclk_prev_q;
   wire [7:0]   sp_idx  = sh_q[14:7];
   wire         spi_wr  = sel && sp_q == SP_WDATA && sclk_rise && bit_q == `ADCT_SPI_FRAME_LAST;
   wire [7:0]   spi_byte = {sh_q[6:0], sdio_f};

   // Sample clock divider; differential mode needs a divider of two or more for its half slot.
   wire         run      = pwr_q == PW_RUN;
   wire [2:0]   div_m1   = (cfg_q.lvds && cfg_q.div_m1 == 3'h0) ? 3'h1 : cfg_q.div_m1;
   wire [3:0]   div      = {1'b0, div_m1} + 4'h1;
   wire [2:0]   half_m1  = 3'((div >> 1) - 4'h1);
   wire         samp_stb = cnt_q >= div_m1;
   wire         mid_stb  = div_m1 != 3'h0 && cnt_q == half_m1;
   wire         sync_rise = sync_q && !sync_prev_q;
   wire [31:0]  min_ksps = cfg_q.dcs_en ? `ADCT_MIN_KSPS_DCS : `ADCT_MIN_KSPS_NODCS;
   wire         rate_ok  = min_ksps * {28'h0, div} <= `ADCT_CLK_KSPS;
   wire [7:0]   stat     = {4'h0, !o_conv_ready, o_data_valid, rate_ok, run};
   wire         rise_tap = rise_sh_q[dly_q];
   wire         fall_tap = fall_sh_q[dly_q];
   adct_samp_t  last;
   assign last = pipe_q[`ADCT_LAT_CYC-2];

   wire axi_cfg_we = axi_wr && w_en_q && aw_idx_q == `ADCT_IDX_CFG;
   wire axi_dly_we = axi_wr && w_en_q && aw_idx_q == `ADCT_IDX_DLY;
   wire spi_cfg_we = spi_wr && sp_idx == `ADCT_IDX_CFG && !axi_cfg_we;
   wire spi_dly_we = spi_wr && sp_idx == `ADCT_IDX_DLY && !axi_dly_we;
   wire [7:0] cfg_wval = axi_cfg_we ? w_byte_q : spi_byte;
   wire [7:0] dly_wval = axi_dly_we ? w_byte_q : spi_byte;

   assign o_awake = run;

   adct_sync3 #(
      .W   (3),
      .RST (3'h2)
   ) u_pins (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_d     ({i_sclk, i_serial_select_low_n, i_sdio}),
      .o_q     (pin_f)
   );

   // Popping on every sample strobe keeps the latency fixed; a fast source is held off.
   adct_fifo #(
      .W     ($bits(adct_pair_t)),
      .DEPTH (`ADCT_FIFO_DEPTH)
   ) u_fifo (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_valid (i_conv_valid),
      .o_ready (o_conv_ready),
      .i_data  (i_conv_data),
      .o_valid (fifo_vld),
      .i_ready (samp_stb),
      .o_data  (fifo_data)
   );

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_got_q       <= 1'b0;
         w_got_q        <= 1'b0;
         aw_idx_q       <= 8'h00;
         w_byte_q       <= 8'h00;
         w_en_q         <= 1'b0;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp  <= `ADCT_RESP_OK;
      end else begin
         if (aw_hs) begin
            aw_got_q <= 1'b1;
            aw_idx_q <= reg_index(i_s_axi_awaddr);
         end else if (axi_wr) begin
            aw_got_q <= 1'b0;
         end
         if (w_hs) begin
            w_got_q  <= 1'b1;
            w_byte_q <= i_s_axi_wdata[7:0];
            w_en_q   <= i_s_axi_wstrb[0];
         end else if (axi_wr) begin
            w_got_q <= 1'b0;
         end
         if (axi_wr) begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= idx_mapped(aw_idx_q) ? `ADCT_RESP_OK : `ADCT_RESP_SLVERR;
         end else if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata  <= 32'h0000_0000;
         o_s_axi_rresp  <= `ADCT_RESP_OK;
      end else if (ar_hs) begin
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata  <= {24'h00_0000, reg_read(ar_idx, cfg_q, dly_q, stat)};
         o_s_axi_rresp  <= idx_mapped(ar_idx) ? `ADCT_RESP_OK : `ADCT_RESP_SLVERR;
      end else if (i_s_axi_rready) begin
         o_s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_q <= `ADCT_CFG_RST;
         dly_q <= `ADCT_DLY_RST;
      end else begin
         if (axi_cfg_we || spi_cfg_we) begin
            cfg_q      <= cfg_wval;
            cfg_q.rsvd <= 1'b0;
         end
         if (axi_dly_we || spi_dly_we) begin
            dly_q <= dly_wval[`ADCT_DLY_W-1:0];
         end
      end
   end

   // Power state; output stays marked invalid until the wake interval has run out.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pwr_q      <= PW_WAKE;
         wake_cnt_q <= 32'h0000_0000;
      end else begin
         wake_cnt_q <= (pwr_q == PW_WAKE) ? wake_cnt_q + 32'h1 : 32'h0000_0000;
         case (pwr_q)
            PW_DOWN: pwr_q <= cfg_q.pdwn ? PW_DOWN : PW_WAKE;
            PW_WAKE: begin
               if (cfg_q.pdwn) begin
                  pwr_q <= PW_DOWN;
               end else if (wake_cnt_q == P_WAKE_CYC - 1) begin
                  pwr_q <= PW_RUN;
               end
            end
            PW_RUN:  pwr_q <= cfg_q.pdwn ? PW_DOWN : PW_RUN;
            default: pwr_q <= PW_DOWN;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_q      <= 1'b0;
         sync_prev_q <= 1'b0;
         cnt_q       <= 3'h0;
      end else begin
         sync_q      <= i_sync;
         sync_prev_q <= sync_q;
         if ((sync_rise && cfg_q.sync_en) || samp_stb) begin
            cnt_q <= 3'h0;
         end else begin
            cnt_q <= 3'(cnt_q + 3'h1);
         end
      end
   end

   // Conversion pipeline counted in sample strobes, so latency scales with the divider.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         samp_q        <= '0;
         b_hold_q      <= '0;
         o_data_a      <= '0;
         o_data_b      <= '0;
         o_data_chan_b <= 1'b0;
         o_data_valid  <= 1'b0;
         for (int i = 0; i < `ADCT_LAT_CYC - 1; i++) begin
            pipe_q[i] <= '0;
         end
      end else begin
         if (samp_stb) begin
            samp_q    <= '{vld: fifo_vld && run, d: fifo_vld ? fifo_data : '0};
            pipe_q[0] <= samp_q;
            for (int i = 1; i < `ADCT_LAT_CYC - 1; i++) begin
               pipe_q[i] <= pipe_q[i-1];
            end
            o_data_a      <= last.d.a;
            o_data_b      <= cfg_q.lvds ? '0 : last.d.b;
            o_data_chan_b <= 1'b0;
            b_hold_q      <= last.d.b;
            o_data_valid  <= last.vld && run;
         end else if (mid_stb && cfg_q.lvds) begin
            o_data_a      <= b_hold_q;
            o_data_chan_b <= 1'b1;
         end
         if (!run) begin
            o_data_valid <= 1'b0;
         end
      end
   end

   // Data clock edges trail the data change by one cycle plus the programmed delay.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rise_sh_q           <= '0;
         fall_sh_q           <= '0;
         o_output_data_clock <= 1'b0;
      end else begin
         rise_sh_q <= {rise_sh_q[`ADCT_DLY_TAPS-2:0], samp_stb};
         fall_sh_q <= {fall_sh_q[`ADCT_DLY_TAPS-2:0], mid_stb};
         if (div_m1 == 3'h0) begin
            o_output_data_clock <= rise_tap ? !o_output_data_clock : o_output_data_clock;
         end else if (rise_tap) begin
            o_output_data_clock <= 1'b1;
         end else if (fall_tap) begin
            o_output_data_clock <= 1'b0;
         end
      end
   end

   // Serial port: 16 instruction bits (read flag first, low address byte last), 8 data bits.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sclk_prev_q <= 1'b0;
         sp_q        <= SP_IDLE;
         bit_q       <= 5'h00;
         sh_q        <= 16'h0000;
         rd_q        <= 8'h00;
         o_sdio      <= 1'b0;
         o_sdio_oe   <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_f;
         if (!sel) begin
            sp_q      <= SP_IDLE;
            bit_q     <= 5'h00;
            o_sdio_oe <= 1'b0;
         end else begin
            if (sclk_rise) begin
               bit_q <= 5'(bit_q + 5'h01);
               sh_q  <= {sh_q[14:0], sdio_f};
            end
            case (sp_q)
               SP_IDLE: sp_q <= SP_INSTR;
               SP_INSTR: begin
                  if (sclk_rise && bit_q == `ADCT_SPI_INSTR_LAST) begin
                     sp_q <= sh_q[14] ? SP_RDATA : SP_WDATA;
                     rd_q <= reg_read({sh_q[6:0], sdio_f}, cfg_q, dly_q, stat);
                  end
               end
               SP_WDATA: begin
                  if (sclk_rise && bit_q == `ADCT_SPI_FRAME_LAST) begin
                     sp_q <= SP_DONE;
                  end
               end
               SP_RDATA: begin
                  if (sclk_fall) begin
                     o_sdio_oe <= 1'b1;
                     o_sdio    <= rd_q[7];
                     rd_q      <= {rd_q[6:0], 1'b0};
                  end else if (sclk_rise && bit_q == `ADCT_SPI_FRAME_LAST) begin
                     o_sdio_oe <= 1'b0;
                     sp_q      <= SP_DONE;
                  end
               end
               SP_DONE: sp_q <= SP_DONE;
               default: sp_q <= SP_IDLE;
            endcase
         end
      end
   end

   // Helper counters used only by the checks below.
   logic [7:0] stable_q;
   logic [3:0] since_q;
   adct_cfg_t  cfg_prev_q;
   logic [`ADCT_DLY_W-1:0] dly_prev_q;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stable_q   <= 8'h00;
         since_q    <= 4'h0;
         cfg_prev_q <= '0;
         dly_prev_q <= '0;
      end else begin
         cfg_prev_q <= cfg_q;
         dly_prev_q <= dly_q;
         stable_q   <= (cfg_q != cfg_prev_q || dly_q != dly_prev_q || sync_rise) ? 8'h00 :
                       (stable_q == 8'hFF ? stable_q : 8'(stable_q + 8'h01));
         since_q    <= samp_stb ? 4'h0 : 4'(since_q + 4'h1);
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_cmos_latency: assert property (stable_q > 8'h10 && div_m1 == 3'h0 && !cfg_q.lvds |->
      o_data_a == $past(samp_q.d.a, 12)) else $error("single-ended latency wrong");
   a_lvds_b_slot: assert property (mid_stb && cfg_q.lvds && !samp_stb |=>
      o_data_chan_b && o_data_a == $past(b_hold_q)) else $error("B slot wrong");
   a_lvds_a_slot: assert property (samp_stb && cfg_q.lvds |=> !o_data_chan_b ##0
      o_data_a == $past(last.d.a)) else $error("A slot wrong");
   a_wake_hold: assert property (pwr_q == PW_WAKE && !cfg_q.pdwn &&
      wake_cnt_q != P_WAKE_CYC - 1 |=> pwr_q == PW_WAKE) else $error("woke early");
   a_asleep_invalid: assert property (pwr_q != PW_RUN |=> !o_data_valid)
      else $error("data valid while waking");
   a_dclk_delay: assert property (stable_q > 8'h40 && div_m1 != 3'h0 &&
      {1'b0, dly_q} < {3'h0, div_m1} && $rose(o_output_data_clock) |->
      since_q == 4'({1'b0, dly_q} + 6'h01)) else $error("data clock delay wrong");
   a_rate_period: assert property (stable_q > 8'h10 && samp_stb |-> since_q == {1'b0, div_m1})
      else $error("sample period wrong");
   a_rate_floor: assert property ((cfg_q.dcs_en && div_m1 >= 3'h2) ||
      (!cfg_q.dcs_en && div_m1 >= 3'h4) |-> !stat[1]) else $error("rate floor missed");
   a_sdio_enable: assert property ($rose(o_sdio_oe) |-> $past(sclk_fall) &&
      $past(sp_q) == SP_RDATA) else $error("sdio enabled off falling edge");
   a_sdio_release: assert property ($fell(o_sdio_oe) |-> $past(sclk_rise) || $past(!sel))
      else $error("sdio released off rising edge");
   a_sync_phase: assert property (sync_rise && cfg_q.sync_en |-> ##[1:8] samp_stb)
      else $error("sync did not realign divider");

   c_lvds_b: cover property (mid_stb && cfg_q.lvds ##1 o_data_chan_b);
   c_spi_read: cover property ($fell(o_sdio_oe) && sp_q == SP_DONE);
   c_wake_done: cover property (pwr_q == PW_WAKE ##1 pwr_q == PW_RUN);
   c_fifo_full: cover property (!o_conv_ready && i_conv_valid);
endmodule

/* File: verif/adct_capture.sv */
// Capture-side model that registers output words on the data clock.
`timescale 1ns/100ps
`include "adct_consts.svh"
module adct_capture (
   input  wire logic                i_dclk,
   input  wire logic                i_valid,
   input  wire logic [`ADCT_DW-1:0] i_a,
   output logic      [`ADCT_DW-1:0] o_last_a
);
   // At divide-by-1 the clock toggles once a sample, so both edges qualify data.
   always @(i_dclk) begin
      if (i_valid) o_last_a <= i_a;
   end
endmodule

/* File: verif/tb.sv */
// Register, latency, buffer, data clock and serial port tests of the converter timing core.
`timescale 1ns/100ps
`include "adct_consts.svh"
module tb
   import adct_pkg::*;
;
   logic i_clk = 0, i_rst_n = 0, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0, cv = 0;
   logic sync = 0, sclk = 0, sel_n = 1, hoe = 0, hbit = 0;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0;
   adct_pair_t cd = '0;
   wire logic awr, wr_r, bv, arr, rv, crdy, sdo, soe, chb, dv, dclk, awake;
   wire logic [1:0] br, rr;
   wire logic [31:0] rdat;
   wire logic [`ADCT_DW-1:0] da, db, cap;
   // Serial data line has a pull-up, so a released line reads high.
   wire logic sdw = soe ? sdo : (hoe ? hbit : 1'b1);
   int miscompares = 0, n_tests = 0, cyc = 0;
   adct_top #(.P_WAKE_CYC(200)) adct_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd),
      .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_r), .o_s_axi_bresp(br),
      .o_s_axi_bvalid(bv), .i_s_axi_bready(brd), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
      .o_s_axi_arready(arr), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv),
      .i_s_axi_rready(rrd), .i_conv_valid(cv), .i_conv_data(cd), .o_conv_ready(crdy),
      .i_sync(sync), .i_sclk(sclk), .i_serial_select_low_n(sel_n), .i_sdio(sdw), .o_sdio(sdo),
      .o_sdio_oe(soe), .o_data_a(da), .o_data_b(db), .o_data_chan_b(chb), .o_data_valid(dv),
      .o_output_data_clock(dclk), .o_awake(awake));
   adct_capture adct_capture_inst (.i_dclk(dclk), .i_valid(dv), .i_a(da), .o_last_a(cap));
   always #12.5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 6000) begin
         miscompares++;
         results();
      end
   end
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      awa <= a;
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
      do begin
         @(posedge i_clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_r) wv <= 1'b0;
      end while (!bv);
      r = br;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      ara <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
      do begin
         @(posedge i_clk);
         if (arv && arr) arv <= 1'b0;
      end while (!rv);
      d = rdat;
      r = rr;
   endtask
   task automatic push(input adct_pair_t w);
      cv <= 1'b1;
      cd <= w;
      @(posedge i_clk);
      cv <= 1'b0;
   endtask
   // Counts edges until the word shows; values read just after an edge are pre-edge.
   task automatic seek(input logic [13:0] v, input logic c, inout int k);
      while (!(dv && da === v && chb === c) && k < 400) begin
         @(posedge i_clk);
         k++;
      end
   endtask
   task automatic sbit(input logic b, output logic r, output logic oe);
      hbit <= b;
      repeat (8) @(posedge i_clk);
      r = sdw;
      oe = soe;
      sclk <= 1'b1;
      repeat (8) @(posedge i_clk);
      sclk <= 1'b0;
   endtask
   initial begin : main
      logic [1:0] r;
      logic [31:0] d;
      logic b, oe;
      logic [7:0] v;
      static logic [7:0] cf [4] = '{8'h04, 8'h74, 8'h30, 8'h34};
      static logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      int k, ka, n, rel;
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rel = cyc;
      rd(12'h020, d, r); chk(d, 32'h04);
      rd(12'h05C, d, r); chk(d, 32'h00);
      wr(12'h05C, 8'h15, r); chk(32'(r), 32'h0);
      rd(12'h05C, d, r); chk(d, 32'h15);
      wr(12'h100, 8'h55, r); chk(32'(r), 32'h2);
      rd(12'h100, d, r); chk(32'(r), 32'h2);
      $display("test registers done");
      while (cyc < rel + 190) @(posedge i_clk);
      chk(32'(awake), 32'h0);
      while (cyc < rel + 215) @(posedge i_clk);
      chk(32'(awake), 32'h1);
      $display("test wake done");
      for (k = 0; k < 4; k++) begin
         wr(12'h020, cf[k], r); rd(12'h024, d, r); chk(32'(d[1]), 32'(ex[k]));
      end
      $display("test rate floor done");
      wr(12'h020, 8'h04, r);
      push({14'h1ABC, 14'h0555});
      // One edge from push to pop, twelve of latency, and the view trails by one edge.
      k = 0; seek(14'h1ABC, 1'b0, k); chk(32'(k), `ADCT_LAT_CYC + 2);
      chk(32'(db), 32'h0555);
      wr(12'h020, 8'h16, r);
      push({14'h2AAA, 14'h1111});
      k = 0; seek(14'h2AAA, 1'b0, k); ka = k; seek(14'h1111, 1'b1, k);
      chk(32'(k - ka), 32'h1);
      chk(32'(db), 32'h0);
      $display("test latency done");
      wr(12'h05C, 8'h03, r); wr(12'h020, 8'hF4, r);
      sync <= 1'b1;
      @(posedge i_clk);
      sync <= 1'b0;
      cv <= 1'b1;
      n = 0;
      do begin
         cd <= {14'(n + 1), 14'(n + 1)};
         @(posedge i_clk);
         if (crdy) n++;
      end while (crdy && n < 12);
      cv <= 1'b0;
      chk(32'(n >= `ADCT_FIFO_DEPTH), 32'h1);
      k = 0; seek(14'h0001, 1'b0, k); ka = k; b = dclk;
      while (!(dclk && !b) && k < 400) begin
         b = dclk;
         @(posedge i_clk);
         k++;
      end
      chk(32'(k - ka), 32'h4);
      repeat (150) @(posedge i_clk);
      chk(32'(crdy), 32'h1);
      chk(32'(cap), 32'(n));
      $display("test buffer and data clock done");
      sel_n <= 1'b0;
      hoe <= 1'b1;
      for (k = 15; k >= 0; k--) begin
         sbit(k == 15 || (k < 8 && ((8'h17 >> k) & 1)), b, oe); chk(32'(oe), 32'h0);
      end
      hoe <= 1'b0;
      for (k = 7; k >= 0; k--) begin
         sbit(1'b0, v[k], oe); chk(32'(oe), 32'h1);
      end
      chk(32'(v), 32'h03);
      chk(32'(soe), 32'h0);
      sel_n <= 1'b1;
      $display("test serial read done");
      repeat (8) @(posedge i_clk);
      sel_n <= 1'b0;
      hoe <= 1'b1;
      for (k = 23; k >= 0; k--) begin
         sbit(1'(24'h00_170A >> k), b, oe); chk(32'(oe), 32'h0);
      end
      sel_n <= 1'b1;
      hoe <= 1'b0;
      rd(12'h05C, d, r); chk(d, 32'h0A);
      $display("test serial write done");
      results();
   end
endmodule
